/* File: logon_sync_monitor.sv */
/*
  Port-level checks for the logon and sync control block.
  Bound to the control block; sees only its ports.
*/
module logon_sync_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        logon_tx_pulse,
  input wire logic        logon_dedicated,
  input wire logic        logon_with_hwid,
  input wire logic        logon_ok,
  input wire logic        logon_fail,
  input wire logic        sync_ok,
  input wire logic        sync_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic      pend_q;
  logic      sync_q;
  logic      grant_q;
  wire logic wr    = psel && penable && pwrite && pready;
  wire logic wr_ev = wr && paddr == logon_sync_pkg::OFS_EVENT;
  wire logic start = wr && paddr == logon_sync_pkg::OFS_CTRL && pwdata[0] && !pend_q && !sync_q;
  wire logic outc  = logon_ok || logon_fail || sync_ok || sync_fail;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Track which procedure is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q  <= 1'b0;
      sync_q  <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      pend_q  <= logon_tx_pulse || (pend_q && !logon_ok && !logon_fail);
      sync_q  <= logon_ok || (sync_q && !sync_ok && !sync_fail);
      grant_q <= (wr_ev && pwdata[logon_sync_pkg::EV_RA_GRANT]) || (grant_q && !logon_tx_pulse);
    end
  end
  property p_sw_gate; start && !pwdata[1] |=> !logon_tx_pulse [*4]; endproperty
  a_sw_gate: assert property (p_sw_gate) else $error("Logon burst without software clearance");
  property p_ltu_gate; start && pwdata[3:1] == 3'b111 |=> !logon_tx_pulse [*4]; endproperty
  a_ltu_gate: assert property (p_ltu_gate) else $error("Logon burst without timing support");
  property p_dedicated; start && pwdata[1] && !pwdata[2] && pwdata[4] |=> logon_tx_pulse && logon_dedicated; endproperty
  a_dedicated: assert property (p_dedicated) else $error("Dedicated slot not used at once");
  property p_kind; logon_tx_pulse |-> logon_with_hwid != logon_dedicated; endproperty
  a_kind: assert property (p_kind) else $error("Identifier presence wrong for slot kind");
  property p_ra_grant; logon_tx_pulse && !logon_dedicated |-> grant_q; endproperty
  a_ra_grant: assert property (p_ra_grant) else $error("Random burst without load grant");
  property p_reject; wr_ev && pwdata[logon_sync_pkg::EV_REJECT] && pend_q |=> logon_fail; endproperty
  a_reject: assert property (p_reject) else $error("Reject did not end logon");
  property p_sync_order; sync_ok || sync_fail |-> sync_q; endproperty
  a_sync_order: assert property (p_sync_order) else $error("Sync outcome without logon");
  property p_pulse; outc |=> !outc; endproperty
  a_pulse: assert property (p_pulse) else $error("Outcome held over one cycle");
endmodule

bind terminal_logon_sync_control logon_sync_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .logon_tx_pulse(logon_tx_pulse),
  .logon_dedicated(logon_dedicated), .logon_with_hwid(logon_with_hwid), .logon_ok(logon_ok),
  .logon_fail(logon_fail), .sync_ok(sync_ok), .sync_fail(sync_fail)
);

/* File: logon_sync_pkg.sv */
/*
  Shared constants for the terminal logon and synchronization control block:
  APB register offsets, field positions, reset values and timing figures.
  Assumes a 100 MHz pclk and a 32-bit APB bus with word-aligned registers.
*/
package logon_sync_pkg;
  localparam int unsigned CLK_MHZ = 100;

  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_CFG0    = 12'h004;
  localparam logic [11:0] OFS_CFG1    = 12'h008;
  localparam logic [11:0] OFS_THRESH  = 12'h00C;
  localparam logic [11:0] OFS_EVENT   = 12'h010;
  localparam logic [11:0] OFS_CORR    = 12'h014;
  localparam logic [11:0] OFS_SFS     = 12'h018;
  localparam logic [11:0] OFS_STATUS  = 12'h01C;
  localparam logic [11:0] OFS_TIMING  = 12'h020;

  // Control register bits
  localparam int unsigned CTRL_START    = 0;
  localparam int unsigned CTRL_SW_OK    = 1;
  localparam int unsigned CTRL_NEED_LTU = 2;
  localparam int unsigned CTRL_LTU_FLAG = 3;
  localparam int unsigned CTRL_DED_AVL  = 4;
  localparam int unsigned CTRL_RA_AVL   = 5;

  // Event register bits (write-one pulses)
  localparam int unsigned EV_ACCEPT   = 0;
  localparam int unsigned EV_REJECT   = 1;
  localparam int unsigned EV_CTRL_TX  = 2;
  localparam int unsigned EV_RESP     = 3;
  localparam int unsigned EV_RA_GRANT = 4;
  localparam int unsigned EV_SFS_ASGN = 5;
  localparam int unsigned EV_ADDR     = 6;

  localparam logic [7:0]  MAX_LOGON_RST   = 8'h04;
  localparam logic [7:0]  MAX_LOSS_RST    = 8'h03;
  localparam logic [7:0]  MAX_TRIES_RST   = 8'h10;
  localparam logic [15:0] RESP_TMO_RST    = 16'h03E8;
  localparam logic [15:0] HOLDOFF_RST     = 16'h0100;
  localparam logic [31:0] SILENCE_RST     = 32'h05F5_E100;

  // Timeout unit is 1 us
  localparam int unsigned TICK_US    = 1;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_OFF, ST_LOGON_WAIT, ST_HOLDOFF, ST_SYNC_WAIT, ST_SYNCED
  } term_state_type;
endpackage

/* File: network_controller_model.sv */
/*
  Far-side model: receives logon bursts and tallies them by slot kind.
  Assumes burst strobes are one-cycle pulses on pclk.
*/
module network_controller_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic logon_tx_pulse,
  input  wire logic logon_dedicated,
  input  wire logic logon_with_hwid,
  output int        bursts,
  output int        ra_bursts,
  output int        kind_err
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bursts    <= 0;
      ra_bursts <= 0;
      kind_err  <= 0;
    end else if (logon_tx_pulse === 1'b1) begin
      bursts <= bursts + 1;
      if (logon_dedicated !== 1'b1) ra_bursts <= ra_bursts + 1;
      // Identifier only in random bursts
      if (logon_with_hwid === logon_dedicated) kind_err <= kind_err + 1;
    end
  end
endmodule

/* File: terminal_logon_sync_control.sv */
/*
  Logon, TDMA synchronization and sync monitoring control for a return-link
  terminal, reached over APB. Assumes software decodes forward-link tables
  and writes the results as events and corrections.
*/
// The register addresses and register access over APB are this design's own decisions.
module terminal_logon_sync_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             logon_tx_pulse,
  output logic             logon_dedicated,
  output logic             logon_with_hwid,
  output logic             logon_ok,
  output logic             logon_fail,
  output logic             sync_ok,
  output logic             sync_fail,
  output logic             monitor_fail,
  output logic             silent_logoff,
  output logic      [15:0] active_sfs,
  output logic      [15:0] timing_corr
);
  logic        wr_en;
  logic        rd_en;
  logic [31:0] ctrl_q;
  logic [31:0] cfg0_q;
  logic [31:0] cfg1_q;
  logic [31:0] thresh_q;
  logic [31:0] corr_q;
  logic [31:0] sfs_q;
  logic [31:0] timing_q;
  logic [31:0] silence_lim_q;
  logic [6:0]  ev;
  logic [31:0] prdata_d;
  logic        err_d;
  logic [15:0] freq_err;
  logic [15:0] time_err;
  logic        corr_ok;
  logic        corr_bad;
  logic [7:0]  max_logon;
  logic [7:0]  max_loss;
  logic [7:0]  max_tries;
  logic [15:0] resp_tmo;
  logic [15:0] holdoff_max;
  logic [15:0] lfsr_q;
  logic [7:0]  tick_q;
  logic        tick;
  logic [15:0] wait_q;
  logic [7:0]  sent_q;
  logic [7:0]  loss_q;
  logic [7:0]  tries_q;
  logic        ra_pending_q;
  logic [31:0] silence_q;
  logon_sync_pkg::term_state_type state_q;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign ev      = (wr_en && paddr == logon_sync_pkg::OFS_EVENT) ? pwdata[6:0] : 7'h00;

  assign max_logon   = cfg0_q[7:0];
  assign max_loss    = cfg0_q[15:8];
  assign max_tries   = cfg0_q[23:16];
  assign resp_tmo    = cfg1_q[15:0];
  assign holdoff_max = cfg1_q[31:16];
  assign freq_err    = corr_q[15:0];
  assign time_err    = corr_q[31:16];

  function automatic logic below(input logic [15:0] err, input logic [15:0] th);
    below = (th != 16'h0000) && (err < th);
  endfunction

  function automatic logic above(input logic [15:0] err, input logic [15:0] th);
    above = (th != 16'h0000) && (err > th);
  endfunction

  // Both thresholds zero means unconditional success
  assign corr_ok  = (thresh_q == 32'h0000_0000) ||
                    (below(freq_err, thresh_q[15:0]) && below(time_err, thresh_q[31:16]));
  assign corr_bad = above(freq_err, thresh_q[15:0]) || above(time_err, thresh_q[31:16]);

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q        <= 32'h0000_0000;
      cfg0_q        <= {8'h00, logon_sync_pkg::MAX_TRIES_RST, logon_sync_pkg::MAX_LOSS_RST,
                        logon_sync_pkg::MAX_LOGON_RST};
      cfg1_q        <= {logon_sync_pkg::HOLDOFF_RST, logon_sync_pkg::RESP_TMO_RST};
      thresh_q      <= 32'h0000_0000;
      corr_q        <= 32'h0000_0000;
      timing_q      <= 32'h0000_0000;
      silence_lim_q <= logon_sync_pkg::SILENCE_RST;
    end else if (wr_en) begin
      if (paddr == logon_sync_pkg::OFS_CTRL) begin
        ctrl_q <= {26'h000_0000, pwdata[5:1], 1'b0};
      end else if (paddr == logon_sync_pkg::OFS_CFG0) begin
        cfg0_q <= pwdata;
      end else if (paddr == logon_sync_pkg::OFS_CFG1) begin
        cfg1_q <= pwdata;
      end else if (paddr == logon_sync_pkg::OFS_THRESH) begin
        thresh_q <= pwdata;
      end else if (paddr == logon_sync_pkg::OFS_CORR) begin
        corr_q <= pwdata;
      end else if (paddr == logon_sync_pkg::OFS_TIMING) begin
        timing_q <= pwdata;
      end else if (paddr == logon_sync_pkg::OFS_STATUS) begin
        silence_lim_q <= pwdata;
      end
    end
  end

  // Operating sequence: map table default, logon response may override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfs_q      <= 32'h0000_0000;
      active_sfs <= 16'h0000;
    end else begin
      if (wr_en && paddr == logon_sync_pkg::OFS_SFS) begin
        sfs_q <= pwdata;
      end
      if (state_q == logon_sync_pkg::ST_OFF || state_q == logon_sync_pkg::ST_LOGON_WAIT) begin
        active_sfs <= sfs_q[15:0];
      end else if (ev[logon_sync_pkg::EV_SFS_ASGN]) begin
        active_sfs <= sfs_q[31:16];
      end
    end
  end

  // Timing correction, grid offset added only when CTRL_NEED_LTU is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_corr <= 16'h0000;
    end else if (ev[logon_sync_pkg::EV_ACCEPT]) begin
      timing_corr <= ctrl_q[logon_sync_pkg::CTRL_NEED_LTU] ?
                     16'(timing_q[15:0] + timing_q[31:16]) : timing_q[15:0];
    end
  end

  // Read mux and slave error on unmapped address
  always_comb begin
    prdata_d = 32'h0000_0000;
    err_d    = 1'b0;
    if (paddr == logon_sync_pkg::OFS_CTRL) begin
      prdata_d = ctrl_q;
    end else if (paddr == logon_sync_pkg::OFS_CFG0) begin
      prdata_d = cfg0_q;
    end else if (paddr == logon_sync_pkg::OFS_CFG1) begin
      prdata_d = cfg1_q;
    end else if (paddr == logon_sync_pkg::OFS_THRESH) begin
      prdata_d = thresh_q;
    end else if (paddr == logon_sync_pkg::OFS_EVENT) begin
      prdata_d = 32'h0000_0000;
    end else if (paddr == logon_sync_pkg::OFS_CORR) begin
      prdata_d = corr_q;
    end else if (paddr == logon_sync_pkg::OFS_SFS) begin
      prdata_d = {active_sfs, sfs_q[15:0]};
    end else if (paddr == logon_sync_pkg::OFS_STATUS) begin
      prdata_d = {5'h00, 3'(state_q), sent_q, loss_q, tries_q};
    end else if (paddr == logon_sync_pkg::OFS_TIMING) begin
      prdata_d = {16'h0000, timing_corr};
    end else begin
      err_d = 1'b1;
    end
  end

  assign prdata  = rd_en ? prdata_d : 32'h0000_0000;
  assign pslverr = psel && penable && err_d;

  // Timebase and hold-off randomiser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 8'h00;
      lfsr_q <= 16'hACE1;
    end else begin
      tick_q <= tick ? 8'h00 : 8'(tick_q + 8'h01);
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end
  assign tick = (tick_q == 8'(logon_sync_pkg::TICK_CYCLES - 1));

  // Main procedure state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q         <= logon_sync_pkg::ST_OFF;
      wait_q          <= 16'h0000;
      sent_q          <= 8'h00;
      loss_q          <= 8'h00;
      tries_q         <= 8'h00;
      ra_pending_q    <= 1'b0;
      logon_tx_pulse  <= 1'b0;
      logon_dedicated <= 1'b0;
      logon_with_hwid <= 1'b0;
      logon_ok        <= 1'b0;
      logon_fail      <= 1'b0;
      sync_ok         <= 1'b0;
      sync_fail       <= 1'b0;
      monitor_fail    <= 1'b0;
    end else begin
      logon_tx_pulse <= 1'b0;
      logon_ok       <= 1'b0;
      logon_fail     <= 1'b0;
      sync_ok        <= 1'b0;
      sync_fail      <= 1'b0;
      monitor_fail   <= 1'b0;
      case (state_q)
        logon_sync_pkg::ST_OFF: begin
          if (wr_en && paddr == logon_sync_pkg::OFS_CTRL && pwdata[logon_sync_pkg::CTRL_START] &&
              pwdata[logon_sync_pkg::CTRL_SW_OK] &&
              !(pwdata[logon_sync_pkg::CTRL_NEED_LTU] && pwdata[logon_sync_pkg::CTRL_LTU_FLAG])) begin
            sent_q       <= 8'h00;
            wait_q       <= 16'h0000;
            ra_pending_q <= !pwdata[logon_sync_pkg::CTRL_DED_AVL];
            state_q      <= logon_sync_pkg::ST_LOGON_WAIT;
            if (pwdata[logon_sync_pkg::CTRL_DED_AVL]) begin
              logon_tx_pulse  <= 1'b1;
              logon_dedicated <= 1'b1;
              logon_with_hwid <= 1'b0;
              sent_q          <= 8'h01;
              wait_q          <= resp_tmo;
            end
          end
        end
        logon_sync_pkg::ST_LOGON_WAIT: begin
          if (ev[logon_sync_pkg::EV_REJECT]) begin
            logon_fail <= 1'b1;
            wait_q     <= 16'((holdoff_max & lfsr_q) + 16'h0001);
            state_q    <= logon_sync_pkg::ST_HOLDOFF;
          end else if (ev[logon_sync_pkg::EV_ACCEPT]) begin
            logon_ok <= 1'b1;
            loss_q   <= 8'h00;
            tries_q  <= 8'h00;
            state_q  <= logon_sync_pkg::ST_SYNC_WAIT;
          end else if (ra_pending_q) begin
            if (ctrl_q[logon_sync_pkg::CTRL_DED_AVL] ||
                (ev[logon_sync_pkg::EV_RA_GRANT] && ctrl_q[logon_sync_pkg::CTRL_RA_AVL])) begin
              logon_tx_pulse  <= 1'b1;
              logon_dedicated <= ctrl_q[logon_sync_pkg::CTRL_DED_AVL];
              logon_with_hwid <= !ctrl_q[logon_sync_pkg::CTRL_DED_AVL];
              sent_q          <= 8'(sent_q + 8'h01);
              wait_q          <= resp_tmo;
              ra_pending_q    <= 1'b0;
            end
          end else if (tick) begin
            if (wait_q > 16'h0001) begin
              wait_q <= 16'(wait_q - 16'h0001);
            end else if (sent_q >= max_logon) begin
              logon_fail <= 1'b1;
              wait_q     <= 16'((holdoff_max & lfsr_q) + 16'h0001);
              state_q    <= logon_sync_pkg::ST_HOLDOFF;
            end else begin
              ra_pending_q <= 1'b1;
            end
          end
        end
        logon_sync_pkg::ST_HOLDOFF: begin
          // Leave only on a tick, so the hold-off is at least one tick unless the loaded count wraps to zero
          if (tick) begin
            if (wait_q == 16'h0000) begin
              state_q <= logon_sync_pkg::ST_OFF;
            end else begin
              wait_q <= 16'(wait_q - 16'h0001);
            end
          end
        end
        logon_sync_pkg::ST_SYNC_WAIT: begin
          if (ev[logon_sync_pkg::EV_RESP] && corr_ok) begin
            sync_ok <= 1'b1;
            loss_q  <= 8'h00;
            state_q <= logon_sync_pkg::ST_SYNCED;
          end else if (ev[logon_sync_pkg::EV_RESP]) begin
            loss_q <= 8'h00;
          end else if (ev[logon_sync_pkg::EV_CTRL_TX]) begin
            tries_q <= 8'(tries_q + 8'h01);
            loss_q  <= 8'(loss_q + 8'h01);
            if (loss_q >= max_loss || tries_q >= max_tries) begin
              sync_fail <= 1'b1;
              state_q   <= logon_sync_pkg::ST_OFF;
            end
          end
        end
        logon_sync_pkg::ST_SYNCED: begin
          if (silent_logoff) begin
            state_q <= logon_sync_pkg::ST_OFF;
          end else if (ev[logon_sync_pkg::EV_RESP] && corr_bad) begin
            monitor_fail <= 1'b1;
            state_q      <= logon_sync_pkg::ST_OFF;
          end else if (ev[logon_sync_pkg::EV_RESP]) begin
            loss_q <= 8'h00;
          end else if (ev[logon_sync_pkg::EV_CTRL_TX]) begin
            loss_q <= 8'(loss_q + 8'h01);
            if (loss_q >= max_loss) begin
              monitor_fail <= 1'b1;
              state_q      <= logon_sync_pkg::ST_OFF;
            end
          end
        end
        default: begin
          state_q <= logon_sync_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Link supervision: count cycles without addressed traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      silence_q <= 32'h0000_0000;
    end else if (state_q != logon_sync_pkg::ST_SYNCED || ev[logon_sync_pkg::EV_ADDR] ||
                 ev[logon_sync_pkg::EV_RESP]) begin
      silence_q <= 32'h0000_0000;
    end else if (!silent_logoff) begin
      silence_q <= 32'(silence_q + 32'h0000_0001);
    end
  end
  assign silent_logoff = (state_q == logon_sync_pkg::ST_SYNCED) && (silence_q >= silence_lim_q);
endmodule

/* File: test_terminal_logon_sync_control.sv */
/*
  Self-checking bench: APB tasks drive logon, sync and monitor flows.
  Assumes the package, block, checker and controller model compile first.
*/
module test_terminal_logon_sync_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk, presetn, psel, penable, pwrite, er;
  logic      [11:0] paddr;
  logic      [31:0] pwdata, rd;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, logon_tx_pulse, logon_dedicated, logon_with_hwid;
  wire logic        logon_ok, logon_fail, sync_ok, sync_fail, monitor_fail, silent_logoff;
  wire logic [15:0] active_sfs, timing_corr;
  int               num_errors, cmp_count, n_lok, n_lfail, n_sok, n_sfail, n_mfail, n_slo;
  int               bursts, ra_bursts, kind_err;

  terminal_logon_sync_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logon_tx_pulse(logon_tx_pulse), .logon_dedicated(logon_dedicated),
    .logon_with_hwid(logon_with_hwid), .logon_ok(logon_ok), .logon_fail(logon_fail),
    .sync_ok(sync_ok), .sync_fail(sync_fail), .monitor_fail(monitor_fail),
    .silent_logoff(silent_logoff), .active_sfs(active_sfs), .timing_corr(timing_corr));
  network_controller_model network_controller (
    .pclk(pclk), .presetn(presetn), .logon_tx_pulse(logon_tx_pulse),
    .logon_dedicated(logon_dedicated), .logon_with_hwid(logon_with_hwid),
    .bursts(bursts), .ra_bursts(ra_bursts), .kind_err(kind_err));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Outcome pulse tallies
  always @(posedge pclk) begin
    n_lok   <= n_lok + (logon_ok === 1'b1);
    n_lfail <= n_lfail + (logon_fail === 1'b1);
    n_sok   <= n_sok + (sync_ok === 1'b1);
    n_sfail <= n_sfail + (sync_fail === 1'b1);
    n_mfail <= n_mfail + (monitor_fail === 1'b1);
    n_slo   <= n_slo + (silent_logoff === 1'b1);
  end

  task final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic rdy;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      rdy = pready;
      rd  = prdata;
      er  = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1) begin
      num_errors++;
      final_report;
    end
    @(posedge pclk);
  endtask

  task ev(input int b);
    apb(1'b1, logon_sync_pkg::OFS_EVENT, 32'h1 << b);
    repeat (3) @(posedge pclk);
  endtask

  task st(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, logon_sync_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[26:24] !== s && n < 200);
    chk("state", {29'h0, s}, {29'h0, rd[26:24]});
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, logon_sync_pkg::OFS_CFG0, 32'h0);
    chk("cfg0", 32'h0010_0304, rd);
    apb(1'b0, logon_sync_pkg::OFS_CFG1, 32'h0);
    chk("cfg1", 32'h0100_03E8, rd);
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, logon_sync_pkg::OFS_CFG0, 32'h0010_0302);
    apb(1'b1, logon_sync_pkg::OFS_CFG1, 32'h0003_0002);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_0011);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_001F);
    repeat (5) @(posedge pclk);
    chk("gated bursts", 32'd0, bursts);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_0033);
    repeat (700) @(posedge pclk);
    chk("bursts", 32'd2, bursts);
    chk("ra bursts", 32'd0, ra_bursts);
    chk("logon fail", 32'd1, n_lfail);
    st(3'd0);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_0023);
    repeat (5) @(posedge pclk);
    chk("ungranted", 32'd2, bursts);
    ev(logon_sync_pkg::EV_RA_GRANT);
    chk("ra burst", 32'd1, ra_bursts);
    chk("kind", 32'd0, kind_err);
    ev(logon_sync_pkg::EV_REJECT);
    chk("reject", 32'd2, n_lfail);
    st(3'd2);
    st(3'd0);
    apb(1'b1, logon_sync_pkg::OFS_SFS, 32'h0022_0011);
    apb(1'b1, logon_sync_pkg::OFS_TIMING, 32'h0005_0100);
    apb(1'b1, logon_sync_pkg::OFS_THRESH, 32'h0);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_0017);
    ev(logon_sync_pkg::EV_ACCEPT);
    chk("logon ok", 32'd1, n_lok);
    chk("timing", 32'h0105, {16'h0, timing_corr});
    st(3'd3);
    ev(logon_sync_pkg::EV_SFS_ASGN);
    chk("sfs", 32'h0022, {16'h0, active_sfs});
    ev(logon_sync_pkg::EV_RESP);
    chk("sync ok", 32'd1, n_sok);
    st(3'd4);
    apb(1'b1, logon_sync_pkg::OFS_THRESH, 32'h0000_0010);
    apb(1'b1, logon_sync_pkg::OFS_CORR, 32'hFFFF_0005);
    ev(logon_sync_pkg::EV_RESP);
    chk("zero thr", 32'd0, n_mfail);
    apb(1'b1, logon_sync_pkg::OFS_CORR, 32'h0000_0020);
    ev(logon_sync_pkg::EV_RESP);
    chk("monitor", 32'd1, n_mfail);
    st(3'd0);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_0013);
    ev(logon_sync_pkg::EV_ACCEPT);
    chk("relogon sfs", 32'h0011, {16'h0, active_sfs});
    apb(1'b1, logon_sync_pkg::OFS_THRESH, 32'h0010_0010);
    ev(logon_sync_pkg::EV_RESP);
    chk("no sync", 32'd1, n_sok);
    repeat (3) ev(logon_sync_pkg::EV_CTRL_TX);
    chk("losses", 32'd0, n_sfail);
    ev(logon_sync_pkg::EV_CTRL_TX);
    chk("sync fail", 32'd1, n_sfail);
    st(3'd0);
    apb(1'b1, logon_sync_pkg::OFS_STATUS, 32'h0000_0200);
    apb(1'b1, logon_sync_pkg::OFS_CORR, 32'h0001_0001);
    apb(1'b1, logon_sync_pkg::OFS_CTRL, 32'h0000_0013);
    ev(logon_sync_pkg::EV_ACCEPT);
    ev(logon_sync_pkg::EV_RESP);
    st(3'd4);
    repeat (300) @(posedge pclk);
    ev(logon_sync_pkg::EV_ADDR);
    repeat (300) @(posedge pclk);
    chk("addressed", 32'd0, n_slo);
    repeat (300) @(posedge pclk);
    chk("silent logoff", 32'd1, n_slo);
    st(3'd0);
    final_report;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    final_report;
  end
endmodule
